// ===== rtl/sds_defines.svh
// Function
// - Transmit and receive halves run independently, each with its own sleep control.
// - Each half has init, transfer, resync states plus sleep and high-impedance; code gives transmit TX_SLEEP, TX_PLL_ACQ, TX_XFER, TX_TRAIN, no resync.
// - Transmit serial output stays undriven while its PLL locks to word clock.
// - Once locked, transmit sends training patterns while training request is high.
// - Training word has upper nine data bits high, lower nine low.
// - Receive word and recovered clock undriven while PLL locks to reference.
// - Acquisition flag stays high until receive locks to data or training.
// - Receiver finds the rising clock edge of training in bounded time.
// - Acquisition flag falls in the same cycle as the first valid word.
// - Each serial word: start bit one, eighteen data bits, stop bit zero.
// - Transmit captures the eighteen parallel bits on each word clock rise.
// - After six word clocks of training request, parallel capture stops until release.
// - Twenty bits per word are shifted out, twenty times the word rate; code shifts one per bit_en, not tied to word clock.
// - Recovered clock is driven synchronous with the received parallel word.
// - Receive output enable decides whether word and recovered clock are driven.
// - Enable low floats those outputs; enable high restores the previous state.
// - Two successive missed clock edges drop acquisition, raise flag, restart.
// - Receive serial input is ignored while receive sleep control is low.
`ifndef SDS_DEFINES_SVH
`define SDS_DEFINES_SVH
`define SDS_DATA_BITS 18
`define SDS_FRAME_BITS 20
`define SDS_TRAIN_WORD 18'h3FE00
`define SDS_TRAIN_FRAME {1'b0, `SDS_TRAIN_WORD, 1'b1}
`define SDS_LAST_BIT 5'h13
`define SDS_MID_BIT 5'h09
`define SDS_TRAIN_HOLD 3'h6
`define SDS_TX_LOCK_EDGES 3'h4
`define SDS_RX_LOCK_EDGES 3'h4
`define SDS_ACQ_WORDS 3'h4
`define SDS_MISS_LIMIT 2'h2
`define SDS_ADR_CTRL 8'h00
`define SDS_ADR_STATUS 8'h04
`define SDS_ADR_RXWORD 8'h08
`define SDS_CTRL_RESET 5'h00
`endif

// ===== rtl/sds_pkg.sv
`include "sds_defines.svh"
package sds_pkg;
	typedef enum logic [1:0] {TX_SLEEP, TX_PLL_ACQ, TX_XFER, TX_TRAIN}
		sds_tx_state_type;
	typedef enum logic [2:0] {RX_SLEEP, RX_REF_ACQ, RX_ACQ, RX_XFER,
		RX_RESYNC} sds_rx_state_type;
	typedef struct packed {
		logic train;
		logic rx_oe;
		logic tx_drive;
		logic rx_sleep_n;
		logic tx_sleep_n;
	} sds_ctrl_type;
	typedef struct packed {
		logic clock;
		logic [`SDS_DATA_BITS-1:0] word;
	} sds_rx_out_type;
endpackage : sds_pkg

// ===== rtl/sds_sync.sv
`timescale 1ns/100ps
module sds_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Foreign level
	input wire logic [W-1:0] d,
	// Synchronised level and its rising edge
	output logic [W-1:0] q,
	output logic [W-1:0] rise
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;
	logic [W-1:0] prev_reg;
	logic [W-1:0] prev_next;

	always_comb begin
		meta_next = d;
		q_next = meta_reg;
		prev_next = q_reg;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_reg <= '0;
			q_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			q_reg <= q_next;
			prev_reg <= prev_next;
		end
	end

	assign q = q_reg;
	assign rise = q_reg & ~prev_reg;
endmodule : sds_sync

// ===== rtl/sds_serdes.sv
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`include "sds_defines.svh"
module sds_serdes #(
	parameter int BIT_DIV = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Transmit half
	input wire logic transmit_word_clock,
	input wire logic [`SDS_DATA_BITS-1:0] parallel_tx_word,
	output logic tx_serial_out,
	output logic tx_serial_oe,
	// Receive half
	input wire logic receive_reference_clock,
	input wire logic rx_serial_in,
	output logic [`SDS_DATA_BITS-1:0] parallel_rx_word,
	output logic parallel_rx_word_oe,
	output logic recovered_clock,
	output logic recovered_clock_oe,
	output logic rx_acquired_n
);
	import sds_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	logic [`SDS_DATA_BITS-1:0] tx_data_s;
	logic [`SDS_DATA_BITS-1:0] unused_rise;
	logic serial_s;
	logic ref_s;
	logic word_s;
	logic serial_rise;
	logic ref_rise;
	logic word_rise;

	// All pins from outside the clock domain pass two flops first
	sds_sync #(.W(`SDS_DATA_BITS + 3)) u_sync (
		.clk(clk),
		.reset(reset),
		.d({parallel_tx_word, rx_serial_in, receive_reference_clock,
			transmit_word_clock}),
		.q({tx_data_s, serial_s, ref_s, word_s}),
		.rise({unused_rise, serial_rise, ref_rise, word_rise})
	);

	// Bit-rate enable shared by both halves
	logic [7:0] div_reg;
	logic [7:0] div_next;
	logic bit_en;

	assign bit_en = (div_reg == 8'(BIT_DIV - 1));

	always_comb begin
		div_next = bit_en ? 8'h00 : div_reg + 8'h01;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_next;
		end
	end

	// Register file
	sds_ctrl_type ctrl_reg;
	sds_ctrl_type ctrl_next;
	logic ack_reg;
	logic ack_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;
	logic [5:0] status;
	sds_tx_state_type tx_state_reg;
	sds_tx_state_type tx_state_next;
	sds_rx_state_type rx_state_reg;
	sds_rx_state_type rx_state_next;
	sds_rx_out_type rx_out_reg;
	sds_rx_out_type rx_out_next;
	logic tx_block;
	logic rx_live;

	assign status = {rx_state_reg == RX_RESYNC, ~rx_acquired_n, rx_live,
		tx_block, tx_state_reg == TX_TRAIN, tx_serial_oe};

	always_comb begin
		ctrl_next = ctrl_reg;
		ack_next = 1'b0;
		dat_next = dat_reg;
		if (wb_cyc_i && wb_stb_i && !ack_reg) begin
			ack_next = 1'b1;
			dat_next = 32'h00000000;
			if (wb_adr_i == `SDS_ADR_CTRL) begin
				dat_next = {27'h0000000, ctrl_reg};
				if (wb_we_i && wb_sel_i[0]) begin
					ctrl_next = wb_dat_i[4:0];
				end
			end else if (wb_adr_i == `SDS_ADR_STATUS) begin
				dat_next = {26'h0000000, status};
			end else if (wb_adr_i == `SDS_ADR_RXWORD) begin
				dat_next = {14'h0000, rx_out_reg.word};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_reg <= `SDS_CTRL_RESET;
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else begin
			ctrl_reg <= ctrl_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// Transmit half
	logic [2:0] tx_edge_reg;
	logic [2:0] tx_edge_next;
	logic [2:0] train_cnt_reg;
	logic [2:0] train_cnt_next;
	logic [`SDS_FRAME_BITS-1:0] next_frame_reg;
	logic [`SDS_FRAME_BITS-1:0] next_frame_next;
	logic [`SDS_FRAME_BITS-1:0] tx_shift_reg;
	logic [`SDS_FRAME_BITS-1:0] tx_shift_next;
	logic [4:0] tx_bit_reg;
	logic [4:0] tx_bit_next;
	logic tx_load;
	logic tx_active;

	assign tx_block = (train_cnt_reg == `SDS_TRAIN_HOLD);
	assign tx_active = (tx_state_reg == TX_XFER) || (tx_state_reg == TX_TRAIN);

	always_comb begin
		tx_state_next = tx_state_reg;
		tx_edge_next = tx_edge_reg;
		train_cnt_next = train_cnt_reg;
		next_frame_next = next_frame_reg;
		tx_shift_next = tx_shift_reg;
		tx_bit_next = tx_bit_reg;
		tx_load = 1'b0;
		case (tx_state_reg)
			TX_SLEEP: begin
				tx_edge_next = 3'h0;
				tx_state_next = TX_PLL_ACQ;
			end
			TX_PLL_ACQ: begin
				tx_bit_next = `SDS_LAST_BIT;
				tx_shift_next = '0;
				if (word_rise) begin
					tx_edge_next = tx_edge_reg + 3'h1;
					if (tx_edge_reg == `SDS_TX_LOCK_EDGES - 3'h1) begin
						tx_state_next = TX_XFER;
					end
				end
			end
			TX_XFER: begin
				if (ctrl_reg.train) begin
					tx_state_next = TX_TRAIN;
				end
			end
			default: begin
				if (!ctrl_reg.train) begin
					tx_state_next = TX_XFER;
				end
			end
		endcase
		if (!ctrl_reg.train) begin
			train_cnt_next = 3'h0;
		end else if (word_rise && !tx_block) begin
			train_cnt_next = train_cnt_reg + 3'h1;
		end
		if (word_rise && !tx_block) begin
			next_frame_next = {1'b0, tx_data_s, 1'b1};
		end
		if (tx_active && bit_en) begin
			if (tx_bit_reg == `SDS_LAST_BIT) begin
				tx_load = 1'b1;
				tx_bit_next = 5'h00;
				if (tx_state_reg == TX_TRAIN) begin
					tx_shift_next = `SDS_TRAIN_FRAME;
				end else begin
					tx_shift_next = next_frame_reg;
				end
			end else begin
				tx_bit_next = tx_bit_reg + 5'h01;
				tx_shift_next = {1'b0, tx_shift_reg[`SDS_FRAME_BITS-1:1]};
			end
		end
		if (!ctrl_reg.tx_sleep_n) begin
			tx_state_next = TX_SLEEP;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			tx_state_reg <= TX_SLEEP;
			tx_edge_reg <= 3'h0;
			train_cnt_reg <= 3'h0;
			next_frame_reg <= '0;
			tx_shift_reg <= '0;
			tx_bit_reg <= 5'h00;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_edge_reg <= tx_edge_next;
			train_cnt_reg <= train_cnt_next;
			next_frame_reg <= next_frame_next;
			tx_shift_reg <= tx_shift_next;
			tx_bit_reg <= tx_bit_next;
		end
	end

	assign tx_serial_out = tx_shift_reg[0];
	assign tx_serial_oe = tx_active && ctrl_reg.tx_drive;

	// Receive half
	logic [2:0] ref_cnt_reg;
	logic [2:0] ref_cnt_next;
	logic [`SDS_FRAME_BITS-1:0] rx_shift_reg;
	logic [`SDS_FRAME_BITS-1:0] rx_shift_next;
	logic [`SDS_FRAME_BITS-1:0] sh_in;
	logic [4:0] rx_bit_reg;
	logic [4:0] rx_bit_next;
	logic slip_reg;
	logic slip_next;
	logic [2:0] good_reg;
	logic [2:0] good_next;
	logic [1:0] miss_reg;
	logic [1:0] miss_next;
	logic acq_n_reg;
	logic acq_n_next;
	logic deliver;
	logic frame_ok;
	logic serial_bit;

	assign serial_bit = ctrl_reg.rx_sleep_n & serial_s;
	assign sh_in = {serial_bit, rx_shift_reg[`SDS_FRAME_BITS-1:1]};
	assign frame_ok = sh_in[0] & ~sh_in[`SDS_FRAME_BITS-1];
	assign rx_live = (rx_state_reg == RX_ACQ) || (rx_state_reg == RX_XFER)
		|| (rx_state_reg == RX_RESYNC);

	always_comb begin
		rx_state_next = rx_state_reg;
		ref_cnt_next = ref_cnt_reg;
		rx_shift_next = rx_shift_reg;
		rx_bit_next = rx_bit_reg;
		slip_next = slip_reg;
		good_next = good_reg;
		miss_next = miss_reg;
		acq_n_next = acq_n_reg;
		rx_out_next = rx_out_reg;
		deliver = 1'b0;
		if (rx_live && bit_en) begin
			rx_shift_next = sh_in;
		end
		case (rx_state_reg)
			RX_SLEEP: begin
				ref_cnt_next = 3'h0;
				rx_state_next = RX_REF_ACQ;
			end
			RX_REF_ACQ: begin
				if (ref_rise) begin
					ref_cnt_next = ref_cnt_reg + 3'h1;
					if (ref_cnt_reg == `SDS_RX_LOCK_EDGES - 3'h1) begin
						rx_state_next = RX_ACQ;
						rx_bit_next = 5'h00;
						good_next = 3'h0;
						slip_next = 1'b0;
					end
				end
			end
			RX_XFER: begin
				if (bit_en) begin
					if (rx_bit_reg == `SDS_MID_BIT) begin
						rx_out_next.clock = 1'b0;
					end
					if (rx_bit_reg == `SDS_LAST_BIT) begin
						rx_bit_next = 5'h00;
						deliver = 1'b1;
						if (frame_ok) begin
							miss_next = 2'h0;
						end else if (miss_reg == `SDS_MISS_LIMIT - 2'h1) begin
							deliver = 1'b0;
							acq_n_next = 1'b1;
							rx_state_next = RX_RESYNC;
							rx_out_next.clock = 1'b0;
							good_next = 3'h0;
						end else begin
							miss_next = miss_reg + 2'h1;
						end
					end else begin
						rx_bit_next = rx_bit_reg + 5'h01;
					end
				end
			end
			default: begin
				if (bit_en) begin
					if (sh_in == `SDS_TRAIN_FRAME) begin
						deliver = 1'b1;
					end else if (slip_reg) begin
						slip_next = 1'b0;
					end else if (rx_bit_reg == `SDS_LAST_BIT) begin
						rx_bit_next = 5'h00;
						if (!frame_ok) begin
							good_next = 3'h0;
							slip_next = 1'b1;
						end else if (good_reg == `SDS_ACQ_WORDS - 3'h1) begin
							deliver = 1'b1;
						end else begin
							good_next = good_reg + 3'h1;
						end
					end else begin
						rx_bit_next = rx_bit_reg + 5'h01;
					end
					if (deliver) begin
						rx_state_next = RX_XFER;
						rx_bit_next = 5'h00;
						miss_next = 2'h0;
						good_next = 3'h0;
					end
				end
			end
		endcase
		if (deliver) begin
			rx_out_next.word = sh_in[`SDS_DATA_BITS:1];
			rx_out_next.clock = 1'b1;
			acq_n_next = 1'b0;
		end
		if (!ctrl_reg.rx_sleep_n) begin
			rx_state_next = RX_SLEEP;
			acq_n_next = 1'b1;
			rx_out_next.clock = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rx_state_reg <= RX_SLEEP;
			ref_cnt_reg <= 3'h0;
			rx_shift_reg <= '0;
			rx_bit_reg <= 5'h00;
			slip_reg <= 1'b0;
			good_reg <= 3'h0;
			miss_reg <= 2'h0;
			acq_n_reg <= 1'b1;
			rx_out_reg <= '0;
		end else begin
			rx_state_reg <= rx_state_next;
			ref_cnt_reg <= ref_cnt_next;
			rx_shift_reg <= rx_shift_next;
			rx_bit_reg <= rx_bit_next;
			slip_reg <= slip_next;
			good_reg <= good_next;
			miss_reg <= miss_next;
			acq_n_reg <= acq_n_next;
			rx_out_reg <= rx_out_next;
		end
	end

	assign parallel_rx_word = rx_out_reg.word;
	assign recovered_clock = rx_out_reg.clock;
	assign parallel_rx_word_oe = rx_live && ctrl_reg.rx_oe;
	assign recovered_clock_oe = rx_live && ctrl_reg.rx_oe;
	assign rx_acquired_n = acq_n_reg;

	property p_tx_hiz;
		!tx_active |-> !tx_serial_oe;
	endproperty
	a_tx_hiz: assert property (p_tx_hiz) else $error("tx driven unlocked");

	property p_tx_frame;
		tx_load |=> tx_shift_reg[0] && !tx_shift_reg[`SDS_FRAME_BITS-1];
	endproperty
	a_tx_frame: assert property (p_tx_frame) else $error("bad framing");

	property p_tx_train;
		tx_load && tx_state_reg == TX_TRAIN |=>
			tx_shift_reg == `SDS_TRAIN_FRAME;
	endproperty
	a_tx_train: assert property (p_tx_train) else $error("bad train");

	property p_tx_capture;
		word_rise && !tx_block |=>
			next_frame_reg[`SDS_DATA_BITS:1] == $past(tx_data_s);
	endproperty
	a_tx_capture: assert property (p_tx_capture) else $error("no capture");

	property p_tx_block;
		word_rise && tx_block && ctrl_reg.train |=> $stable(next_frame_reg);
	endproperty
	a_tx_block: assert property (p_tx_block) else $error("captured");

	property p_rx_hiz;
		rx_state_reg == RX_REF_ACQ |->
			!parallel_rx_word_oe && !recovered_clock_oe && rx_acquired_n;
	endproperty
	a_rx_hiz: assert property (p_rx_hiz) else $error("rx driven");

	property p_rx_oe;
		!ctrl_reg.rx_oe |-> !parallel_rx_word_oe && !recovered_clock_oe;
	endproperty
	a_rx_oe: assert property (p_rx_oe) else $error("rx oe ignored");

	property p_flag_word;
		$fell(rx_acquired_n) |-> recovered_clock && $past(deliver);
	endproperty
	a_flag_word: assert property (p_flag_word) else $error("flag early");

	property p_train_lock;
		rx_live && bit_en && sh_in == `SDS_TRAIN_FRAME && ctrl_reg.rx_sleep_n
			|=> !rx_acquired_n;
	endproperty
	a_train_lock: assert property (p_train_lock) else $error("no lock");

	property p_loss;
		rx_state_reg == RX_XFER && bit_en && rx_bit_reg == `SDS_LAST_BIT
			&& !frame_ok && miss_reg == 2'h1 |=> rx_acquired_n
			&& rx_state_reg inside {RX_RESYNC, RX_SLEEP};
	endproperty
	a_loss: assert property (p_loss) else $error("loss missed");

	property p_sleep;
		!ctrl_reg.rx_sleep_n |=> rx_state_reg == RX_SLEEP && rx_acquired_n;
	endproperty
	a_sleep: assert property (p_sleep) else $error("rx awake");

	c_lock: cover property ($fell(rx_acquired_n));
	c_train: cover property (tx_load && tx_state_reg == TX_TRAIN);
	c_resync: cover property (rx_state_reg == RX_RESYNC);
	c_block: cover property (tx_block && word_rise);
endmodule : sds_serdes

// ===== tb/sds_far_end.sv
`timescale 1ns/100ps
`include "sds_defines.svh"
module sds_far_end (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Mode: 0 released, 1 training, 2 data word, 3 broken framing
	input wire logic [1:0] mode,
	input wire logic [17:0] word,
	// Serial line toward the receive half
	output logic serial
);
	import sds_pkg::*;
	logic [4:0] bit_reg, bit_next;
	logic [19:0] frame_reg, frame_next;
	always_comb begin
		bit_next = (bit_reg == `SDS_LAST_BIT) ? 5'h00 : bit_reg + 5'h01;
		frame_next = frame_reg;
		if (bit_reg == `SDS_LAST_BIT) begin
			case (mode)
				2'h1: frame_next = `SDS_TRAIN_FRAME;
				2'h2: frame_next = {1'b0, word, 1'b1};
				default: frame_next = 20'hFFFFF;
			endcase
		end
		if (reset) begin
			bit_next = 5'h00;
			frame_next = 20'hFFFFF;
		end
	end
	always_ff @(posedge clk) begin
		bit_reg <= bit_next;
		frame_reg <= frame_next;
	end
	// Released line toggles every cycle so no stale level is seen
	assign serial = (mode == 2'h0) ? bit_reg[0] : frame_reg[bit_reg];
endmodule : sds_far_end

// ===== tb/tb.sv
`timescale 1ns/100ps
`include "sds_defines.svh"
module tb;
	import sds_pkg::*;
	logic clk, reset, cyc, stb, we, ack, twc, rrc, rx_in;
	logic tx_out, tx_oe, rclk, rclk_oe, word_oe, acq_n;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic [17:0] tx_word, rx_word, pword;
	logic [1:0] pmode;
	logic [59:0] s;
	sds_ctrl_type c;
	int n_mismatch, n_tests, i;
	sds_serdes DUT (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .transmit_word_clock(twc),
		.parallel_tx_word(tx_word), .tx_serial_out(tx_out),
		.tx_serial_oe(tx_oe), .receive_reference_clock(rrc),
		.rx_serial_in(rx_in), .parallel_rx_word(rx_word),
		.parallel_rx_word_oe(word_oe), .recovered_clock(rclk),
		.recovered_clock_oe(rclk_oe), .rx_acquired_n(acq_n));
	sds_far_end far (.clk(clk), .reset(reset), .mode(pmode), .word(pword),
		.serial(rx_in));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		twc = 1'b0;
		#3.3;
		forever #62.5 twc = ~twc; // Scaled word rate
	end
	initial begin
		rrc = 1'b0;
		#41.7;
		forever #62.5 rrc = ~rrc;
	end
	task report_and_stop;
		$display("mismatches %0d checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wb(input logic w_e, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w_e;
		adr <= a;
		wdat <= d;
		// Ack and read data are taken at the rising edge itself
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		chk("wb_ack_o", 32'h1, 32'(ack));
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task set_ctrl;
		wb(1'b1, `SDS_ADR_CTRL, {27'h0, c});
		@(negedge clk);
	endtask : set_ctrl
	task grab;
		for (int k = 0; k < 60; k++) begin
			@(negedge clk);
			s[k] = tx_out;
		end
	endtask : grab
	// Two whole back-to-back frames at one phase, start bit first
	function automatic logic hit(input logic [59:0] v, input logic [17:0] d);
		logic [19:0] f;
		f = {1'b0, d, 1'b1};
		for (int k = 0; k < 20; k++)
			if (v[k+:20] === f && v[k+20+:20] === f)
				return 1'b1;
		return 1'b0;
	endfunction : hit
	task wait_flag(input logic lvl);
		int k;
		k = 0;
		while (acq_n !== lvl && k < 400) begin
			@(negedge clk);
			k++;
		end
		chk("rx_acquired_n", 32'(lvl), 32'(acq_n));
	endtask : wait_flag
	initial begin
		#400000;
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		void'($urandom(32'hd18e));
		reset = 1'b1;
		{cyc, stb, we, adr, wdat, tx_word, pmode, pword} = '0;
		sel = 4'hF;
		c = '0;
		n_mismatch = 0;
		n_tests = 0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk("tx_serial_oe", 32'h0, 32'(tx_oe));
		chk("rx_word_oe", 32'h0, 32'(word_oe));
		chk("rx_acquired_n", 32'h1, 32'(acq_n));
		wb(1'b1, 8'h10, 32'hFFFF);
		wb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h0, q);
		wb(1'b1, `SDS_ADR_STATUS, 32'h3F);
		wb(1'b0, `SDS_ADR_STATUS, 32'h0);
		chk("status", 32'h0, q);
		wb(1'b0, `SDS_ADR_CTRL, 32'h0);
		chk("ctrl", 32'h0, q);
		c.tx_sleep_n = 1'b1;
		c.tx_drive = 1'b1;
		set_ctrl;
		chk("tx_serial_oe", 32'h0, 32'(tx_oe));
		repeat (80) @(posedge clk);
		@(negedge clk);
		chk("tx_serial_oe", 32'h1, 32'(tx_oe));
		for (i = 0; i < 5; i++) begin
			@(posedge clk);
			tx_word <= (i == 0) ? 18'h00000 : (i == 1) ? 18'h3FFFF
				: 18'($urandom);
			repeat (60) @(posedge clk);
			grab;
			chk("tx frame", 32'h1, 32'(hit(s, tx_word)));
		end
		c.train = 1'b1;
		set_ctrl;
		repeat (120) @(posedge clk);
		tx_word <= 18'($urandom);
		repeat (60) @(posedge clk);
		grab;
		chk("train frame", 32'h1, 32'(hit(s, `SDS_TRAIN_WORD)));
		wb(1'b0, `SDS_ADR_STATUS, 32'h0);
		chk("status train", 32'h7, q & 32'h7);
		c.train = 1'b0;
		set_ctrl;
		repeat (80) @(posedge clk);
		grab;
		chk("tx frame", 32'h1, 32'(hit(s, tx_word)));
		@(posedge clk);
		pmode <= 2'h1;
		c.rx_sleep_n = 1'b1;
		c.rx_oe = 1'b1;
		set_ctrl;
		chk("rx_word_oe", 32'h0, 32'(word_oe));
		chk("rx_acquired_n", 32'h1, 32'(acq_n));
		wait_flag(1'b0);
		chk("rx_word", 32'(`SDS_TRAIN_WORD), 32'(rx_word));
		chk("recovered_clock", 32'h1, 32'(rclk));
		chk("rx_word_oe", 32'h1, 32'(word_oe));
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			pword <= (i == 0) ? 18'h3FFFF : 18'($urandom);
			pmode <= 2'h2;
			repeat (70) @(posedge clk);
			@(negedge clk);
			chk("rx_word", 32'(pword), 32'(rx_word));
			chk("rx_acquired_n", 32'h0, 32'(acq_n));
		end
		wb(1'b0, `SDS_ADR_RXWORD, 32'h0);
		chk("rxword reg", 32'(pword), q);
		c.rx_oe = 1'b0;
		set_ctrl;
		chk("rx_word_oe", 32'h0, 32'(word_oe));
		chk("recovered_clock_oe", 32'h0, 32'(rclk_oe));
		c.rx_oe = 1'b1;
		set_ctrl;
		chk("recovered_clock_oe", 32'h1, 32'(rclk_oe));
		chk("rx_acquired_n", 32'h0, 32'(acq_n));
		chk("rx_word", 32'(pword), 32'(rx_word));
		@(posedge clk);
		pmode <= 2'h3;
		wait_flag(1'b1);
		@(posedge clk);
		pmode <= 2'h1;
		wait_flag(1'b0);
		c.rx_sleep_n = 1'b0;
		set_ctrl;
		chk("rx_word_oe", 32'h0, 32'(word_oe));
		repeat (200) @(posedge clk);
		@(negedge clk);
		chk("rx_acquired_n", 32'h1, 32'(acq_n));
		chk("tx_serial_oe", 32'h1, 32'(tx_oe));
		c.tx_drive = 1'b0;
		set_ctrl;
		chk("tx_serial_oe", 32'h0, 32'(tx_oe));
		report_and_stop;
	end
endmodule : tb
